// file: bspg_limit_dec.sv
`timescale 1ns/1ps
`default_nettype none

module bspg_limit_dec
  import bspg_pkg::*;
(
  input wire logic [2:0] code_i,   // Stored 3-bit threshold code
  output logic [6:0] mag_o         // Magnitude, percent x10 or mV
);

  // Eight-code table shared by low and high limits of every rail
  always_comb begin
    mag_o = BSPG_MAG_C0;
    unique case (code_i)
      3'h0: mag_o = BSPG_MAG_C0;
      3'h1: mag_o = BSPG_MAG_C1;
      3'h2: mag_o = BSPG_MAG_C2;
      3'h3: mag_o = BSPG_MAG_C3;
      3'h4: mag_o = BSPG_MAG_C4;
      3'h5: mag_o = BSPG_MAG_C5;
      3'h6: mag_o = BSPG_MAG_C6;
      3'h7: mag_o = BSPG_MAG_C7;
    endcase
  end

endmodule

`default_nettype wire

// file: bspg_pkg.sv
package bspg_pkg;

  // ***************************************************************
  // Register offsets on the serial control port
  // ***************************************************************
  localparam logic [7:0] BSPG_OFS_RAIL4_SET_A = 8'h14;
  localparam logic [7:0] BSPG_OFS_RAIL4_SET_B = 8'h15;
  localparam logic [7:0] BSPG_OFS_RAIL1_WIN = 8'h18;
  localparam logic [7:0] BSPG_OFS_RAIL2_WIN = 8'h19;
  localparam logic [7:0] BSPG_OFS_RAIL3_WIN = 8'h1A;

  // ***************************************************************
  // Reset values, field positions, sizes
  // ***************************************************************
  localparam logic [7:0] BSPG_RST_SETPOINT = 8'h00;
  localparam logic [7:0] BSPG_RST_WINDOW = 8'h00;
  localparam logic [7:0] BSPG_RDATA_NONE = 8'h00;
  localparam int BSPG_RSVD_MSB = 7;
  localparam int BSPG_RSVD_LSB = 6;
  localparam int BSPG_LOW_MSB = 5;
  localparam int BSPG_LOW_LSB = 3;
  localparam int BSPG_HIGH_MSB = 2;
  localparam int BSPG_HIGH_LSB = 0;
  localparam int BSPG_RAILS = 3;
  localparam int BSPG_SYNC_STAGES = 2;

  // ***************************************************************
  // Threshold magnitudes: percent x10 or millivolts, same figure
  // ***************************************************************
  localparam logic [6:0] BSPG_MAG_C0 = 7'h1E;
  localparam logic [6:0] BSPG_MAG_C1 = 7'h23;
  localparam logic [6:0] BSPG_MAG_C2 = 7'h28;
  localparam logic [6:0] BSPG_MAG_C3 = 7'h32;
  localparam logic [6:0] BSPG_MAG_C4 = 7'h3C;
  localparam logic [6:0] BSPG_MAG_C5 = 7'h46;
  localparam logic [6:0] BSPG_MAG_C6 = 7'h50;
  localparam logic [6:0] BSPG_MAG_C7 = 7'h64;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef struct packed {
    logic [1:0] rsvd;
    logic [2:0] low_limit;
    logic [2:0] high_limit;
  } bspg_window_t;

  typedef struct packed {
    logic [7:0] rail4_code_a;
    logic [7:0] rail4_code_b;
    bspg_window_t [BSPG_RAILS-1:0] win;
  } bspg_regs_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bspg_req_t;

  typedef struct packed {
    logic ack;
    logic hit;
    logic [7:0] rdata;
  } bspg_rsp_t;

  typedef struct packed {
    logic [6:0] low_mag;
    logic [6:0] high_mag;
    logic in_mv;
  } bspg_limit_t;

  typedef struct packed {
    bspg_regs_t regs;
    bspg_rsp_t rsp;
    logic loaded;
    logic [BSPG_RAILS-1:0] range_s1;
    logic [BSPG_RAILS-1:0] range_s2;
    bspg_limit_t [BSPG_RAILS-1:0] lim;
  } bspg_state_t;

  typedef enum logic [2:0] {
    BSPG_SEL_NONE,
    BSPG_SEL_SET_A,
    BSPG_SEL_SET_B,
    BSPG_SEL_WIN1,
    BSPG_SEL_WIN2,
    BSPG_SEL_WIN3
  } bspg_sel_t;

  // ***************************************************************
  // Address decode, shared by read and write paths
  // ***************************************************************
  function automatic bspg_sel_t bspg_decode(input logic [7:0] addr);
    bspg_sel_t sel;
    sel = BSPG_SEL_NONE;
    unique case (addr)
      BSPG_OFS_RAIL4_SET_A: sel = BSPG_SEL_SET_A;
      BSPG_OFS_RAIL4_SET_B: sel = BSPG_SEL_SET_B;
      BSPG_OFS_RAIL1_WIN: sel = BSPG_SEL_WIN1;
      BSPG_OFS_RAIL2_WIN: sel = BSPG_SEL_WIN2;
      BSPG_OFS_RAIL3_WIN: sel = BSPG_SEL_WIN3;
      default: sel = BSPG_SEL_NONE;
    endcase
    return sel;
  endfunction

endpackage

// file: bspg_regs.sv
// Overview of operation
// - Offset 0x14 holds rail 4 setpoint code A, 8 bits RW, reset 0x00, store-loaded.
// - Offset 0x15 holds rail 4 setpoint code B, 8 bits RW, store-loaded.
// - Rail 1 window bits 5:3 pick low limit, -3% up to -10%.
// - Rail 1 window bits 2:0 pick high limit, +3% up to +10%.
// - Rail 1 window at 0x18, reset 0x00, bits 7:6 reserved RW.
// - Rail 2 window at 0x19, reset 0x00, same layout as rail 1.
// - Rail 2 low limit bits 5:3 use the shared eight-code table.
// - Rail 2 high limit bits 2:0 use the shared eight-code table.
// - Rail 3 window sits at 0x1A, reset 0x00.
// - Rail 3 window holds low and high limits, shared table, store-loaded.
`timescale 1ns/1ps
`default_nettype none

module bspg_regs
  import bspg_pkg::*;
(
  input wire logic clk_i,                          // 200 MHz system clock
  input wire logic nrst_i,                         // Async reset, active low
  input wire bspg_req_t req_i,                     // Request from serial port logic
  output bspg_rsp_t rsp_o,                         // Answer, one cycle later
  input wire logic nvm_load_i,                     // Pulse: load defaults from store
  input wire bspg_regs_t nvm_image_i,              // Defaults from nonvolatile_store
  input wire logic [BSPG_RAILS-1:0] mv_range_i,    // Pin: rail uses mV limits
  output logic [7:0] rail4_code_a_o,               // Setpoint code A of rail 4
  output logic [7:0] rail4_code_b_o,               // Setpoint code B of rail 4
  output bspg_limit_t [BSPG_RAILS-1:0] limit_o,    // Decoded window per rail
  output logic loaded_o                            // Defaults have been loaded
);

  // ***************************************************************
  // Reset release and state
  // ***************************************************************
  logic rst_n;
  bspg_state_t st_q;
  bspg_state_t st_d;
  bspg_sel_t sel;
  logic [6:0] low_mag_w [BSPG_RAILS];
  logic [6:0] high_mag_w [BSPG_RAILS];

  bspg_rst_sync u_rst_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .rst_n_o(rst_n)
  );

  // ***************************************************************
  // Threshold decode, one pair of tables per rail
  // ***************************************************************
  for (genvar g = 0; g < BSPG_RAILS; g++) begin : g_rail
    bspg_limit_dec u_low (
      .code_i(st_q.regs.win[g].low_limit),
      .mag_o(low_mag_w[g])
    );
    bspg_limit_dec u_high (
      .code_i(st_q.regs.win[g].high_limit),
      .mag_o(high_mag_w[g])
    );
  end

  assign sel = bspg_decode(req_i.addr);

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  // Store load outranks a host write in the same cycle, so the
  // defaults always land intact after power-up
  always_comb begin
    st_d = st_q;
    st_d.rsp = '0;
    // Range pin crosses in through two flops before use
    st_d.range_s1 = mv_range_i;
    st_d.range_s2 = st_q.range_s1;
    for (int i = 0; i < BSPG_RAILS; i++) begin
      st_d.lim[i].low_mag = low_mag_w[i];
      st_d.lim[i].high_mag = high_mag_w[i];
      st_d.lim[i].in_mv = st_q.range_s2[i];
    end
    if (req_i.valid) begin
      st_d.rsp.ack = 1'b1;
      st_d.rsp.hit = (sel != BSPG_SEL_NONE);
      // Reads return the old value on a same-cycle write
      unique case (sel)
        BSPG_SEL_SET_A: st_d.rsp.rdata = st_q.regs.rail4_code_a;
        BSPG_SEL_SET_B: st_d.rsp.rdata = st_q.regs.rail4_code_b;
        BSPG_SEL_WIN1: st_d.rsp.rdata = st_q.regs.win[0];
        BSPG_SEL_WIN2: st_d.rsp.rdata = st_q.regs.win[1];
        BSPG_SEL_WIN3: st_d.rsp.rdata = st_q.regs.win[2];
        BSPG_SEL_NONE: st_d.rsp.rdata = BSPG_RDATA_NONE;
      endcase
      if (req_i.write && !nvm_load_i) begin
        unique case (sel)
          BSPG_SEL_SET_A: st_d.regs.rail4_code_a = req_i.wdata;
          BSPG_SEL_SET_B: st_d.regs.rail4_code_b = req_i.wdata;
          // Reserved bits 7:6 are kept as written
          BSPG_SEL_WIN1: st_d.regs.win[0] = req_i.wdata;
          BSPG_SEL_WIN2: st_d.regs.win[1] = req_i.wdata;
          BSPG_SEL_WIN3: st_d.regs.win[2] = req_i.wdata;
          BSPG_SEL_NONE: st_d.regs = st_q.regs;
        endcase
      end
    end
    if (nvm_load_i) begin
      st_d.regs = nvm_image_i;
      st_d.loaded = 1'b1;
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.regs.rail4_code_a <= BSPG_RST_SETPOINT;
      st_q.regs.rail4_code_b <= BSPG_RST_SETPOINT;
      st_q.regs.win[0] <= BSPG_RST_WINDOW;
      st_q.regs.win[1] <= BSPG_RST_WINDOW;
      st_q.regs.win[2] <= BSPG_RST_WINDOW;
      st_q.lim[0].low_mag <= BSPG_MAG_C0;
      st_q.lim[0].high_mag <= BSPG_MAG_C0;
      st_q.lim[1].low_mag <= BSPG_MAG_C0;
      st_q.lim[1].high_mag <= BSPG_MAG_C0;
      st_q.lim[2].low_mag <= BSPG_MAG_C0;
      st_q.lim[2].high_mag <= BSPG_MAG_C0;
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************************************************
  // Outputs, all straight from flops
  // ***************************************************************
  assign rsp_o = st_q.rsp;
  assign rail4_code_a_o = st_q.regs.rail4_code_a;
  assign rail4_code_b_o = st_q.regs.rail4_code_b;
  assign limit_o = st_q.lim;
  assign loaded_o = st_q.loaded;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  // Host write to 0x14 lands unless a store load collides
  set_a_write_a: assert property (
    req_i.valid && req_i.write && !nvm_load_i && req_i.addr == 8'h14
    |=> rail4_code_a_o == $past(req_i.wdata))
    else $error("setpoint A write lost");

  // Host write to 0x15 reads back on the following read
  set_b_readback_a: assert property (
    req_i.valid && req_i.write && !nvm_load_i && req_i.addr == 8'h15
    ##1 req_i.valid && !req_i.write && !nvm_load_i && req_i.addr == 8'h15
    |=> rsp_o.ack && rsp_o.hit && rsp_o.rdata == $past(req_i.wdata, 2))
    else $error("setpoint B readback wrong");

  // Rail 1 low code 7 decodes to 10 percent one cycle on
  rail1_low_dec_a: assert property (
    st_q.regs.win[0].low_limit == 3'h7 |=> limit_o[0].low_mag == 7'h64)
    else $error("rail 1 low limit decode wrong");

  // Rail 1 high code 0 decodes to 3 percent
  rail1_high_dec_a: assert property (
    st_q.regs.win[0].high_limit == 3'h0 |=> limit_o[0].high_mag == 7'h1E)
    else $error("rail 1 high limit decode wrong");

  // Rail 1 window keeps reserved bits as written
  rail1_rsvd_keep_a: assert property (
    req_i.valid && req_i.write && !nvm_load_i && req_i.addr == 8'h18
    ##1 req_i.valid && !req_i.write && !nvm_load_i && req_i.addr == 8'h18
    |=> rsp_o.rdata[7:6] == $past(req_i.wdata[7:6], 2))
    else $error("rail 1 reserved bits not kept");

  // Rail 2 window write steers its decoded limits
  rail2_write_dec_a: assert property (
    req_i.valid && req_i.write && !nvm_load_i && req_i.addr == 8'h19
    && req_i.wdata[5:0] == 6'h1D
    |=> ##1 limit_o[1].low_mag == 7'h32 && limit_o[1].high_mag == 7'h46)
    else $error("rail 2 window write not applied");

  // Rail 2 low code 5 decodes to 7 percent
  rail2_low_dec_a: assert property (
    st_q.regs.win[1].low_limit == 3'h5 |=> limit_o[1].low_mag == 7'h46)
    else $error("rail 2 low limit decode wrong");

  // Rail 2 high code 2 decodes to 4 percent
  rail2_high_dec_a: assert property (
    st_q.regs.win[1].high_limit == 3'h2 |=> limit_o[1].high_mag == 7'h28)
    else $error("rail 2 high limit decode wrong");

  // Read of 0x1A answers with the rail 3 window
  rail3_read_a: assert property (
    req_i.valid && req_i.addr == 8'h1A
    |=> rsp_o.ack && rsp_o.hit && rsp_o.rdata == $past(st_q.regs.win[2]))
    else $error("rail 3 window read wrong");

  // Store load sets rail 3 window, decoded one cycle later
  rail3_load_a: assert property (
    nvm_load_i && nvm_image_i.win[2].low_limit == 3'h4
    |=> ##1 limit_o[2].low_mag == 7'h3C)
    else $error("rail 3 default not applied");

  // Range pin reaches the unit flag after three cycles
  unit_follow_a: assert property (
    $stable(mv_range_i[0]) [*4] |-> limit_o[0].in_mv == mv_range_i[0])
    else $error("rail 1 unit flag stale");

  // Unmapped offsets answer with no hit and zero data
  unmapped_zero_a: assert property (
    req_i.valid && req_i.addr == 8'h16
    |=> rsp_o.ack && !rsp_o.hit && rsp_o.rdata == 8'h00)
    else $error("unmapped answer wrong");

  // Offset list kept apart from the decoder, so a decode slip shows up
  logic req_mapped;
  assign req_mapped = req_i.addr inside {BSPG_OFS_RAIL4_SET_A, BSPG_OFS_RAIL4_SET_B,
    BSPG_OFS_RAIL1_WIN, BSPG_OFS_RAIL2_WIN, BSPG_OFS_RAIL3_WIN};

  // Every request is answered on the very next edge
  ack_follow_a: assert property (
    req_i.valid |=> rsp_o.ack)
    else $error("request not acknowledged");

  // The answer stands one cycle only, then the port goes quiet
  idle_quiet_a: assert property (
    !req_i.valid |=> !rsp_o.ack && !rsp_o.hit && rsp_o.rdata == BSPG_RDATA_NONE)
    else $error("answer outstayed its cycle");

  // Mapped offsets report a hit
  hit_mapped_a: assert property (
    req_i.valid && req_mapped |=> rsp_o.hit)
    else $error("mapped offset missed");

  // Unmapped accesses leave every register alone and read as zero
  miss_drop_a: assert property (
    req_i.valid && !req_mapped && !nvm_load_i
    |=> !rsp_o.hit && rsp_o.rdata == BSPG_RDATA_NONE && $stable(st_q.regs))
    else $error("unmapped access disturbed state");

  // Setpoint A reads back the value held before the edge
  set_a_read_a: assert property (
    req_i.valid && req_i.addr == BSPG_OFS_RAIL4_SET_A
    |=> rsp_o.rdata == $past(rail4_code_a_o))
    else $error("setpoint A read wrong");

  // Host write to setpoint B lands on the next edge
  rail4_b_write_a: assert property (
    req_i.valid && req_i.write && !nvm_load_i && req_i.addr == BSPG_OFS_RAIL4_SET_B
    |=> rail4_code_b_o == $past(req_i.wdata))
    else $error("setpoint B write lost");

  // Rail 1 window takes all eight bits, reserved pair included
  win1_write_a: assert property (
    req_i.valid && req_i.write && !nvm_load_i && req_i.addr == BSPG_OFS_RAIL1_WIN
    |=> st_q.regs.win[0] == $past(req_i.wdata))
    else $error("rail 1 window write lost");

  // Rail 2 window takes all eight bits, reserved pair included
  win2_write_a: assert property (
    req_i.valid && req_i.write && !nvm_load_i && req_i.addr == BSPG_OFS_RAIL2_WIN
    |=> st_q.regs.win[1] == $past(req_i.wdata))
    else $error("rail 2 window write lost");

  // Rail 3 window takes all eight bits, reserved pair included
  win3_write_a: assert property (
    req_i.valid && req_i.write && !nvm_load_i && req_i.addr == BSPG_OFS_RAIL3_WIN
    |=> st_q.regs.win[2] == $past(req_i.wdata))
    else $error("rail 3 window write lost");

  // A store load replaces all five registers, host write or not
  load_wins_a: assert property (
    nvm_load_i |=> st_q.regs == $past(nvm_image_i))
    else $error("store load not applied");

  // Loaded flag rises with the first store load
  loaded_set_a: assert property (
    nvm_load_i |=> loaded_o)
    else $error("loaded flag not set");

  // Loaded flag stays up until the next reset
  loaded_hold_a: assert property (
    loaded_o |=> loaded_o)
    else $error("loaded flag dropped");

  // Rail 1 low code 6 decodes to 8 percent
  rail1_low_six_a: assert property (
    st_q.regs.win[0].low_limit == 3'h6 |=> limit_o[0].low_mag == BSPG_MAG_C6)
    else $error("rail 1 low code 6 wrong");

  // Rail 1 high code 1 decodes to 3.5 percent
  rail1_high_one_a: assert property (
    st_q.regs.win[0].high_limit == 3'h1 |=> limit_o[0].high_mag == BSPG_MAG_C1)
    else $error("rail 1 high code 1 wrong");

  // Rail 3 low code 3 decodes to 5 percent
  rail3_low_three_a: assert property (
    st_q.regs.win[2].low_limit == 3'h3 |=> limit_o[2].low_mag == BSPG_MAG_C3)
    else $error("rail 3 low code 3 wrong");

  // Rail 3 high code 7 decodes to 10 percent
  rail3_high_seven_a: assert property (
    st_q.regs.win[2].high_limit == 3'h7 |=> limit_o[2].high_mag == BSPG_MAG_C7)
    else $error("rail 3 high code 7 wrong");

  // Rail 3 unit flag follows its pin, like rail 1
  unit_rail3_a: assert property (
    $stable(mv_range_i[2]) [*4] |-> limit_o[2].in_mv == mv_range_i[2])
    else $error("rail 3 unit flag stale");

  // Decoded limits move only when the stored codes move
  rail1_lim_hold_a: assert property (
    $stable(st_q.regs.win[0])
    |=> $stable(limit_o[0].low_mag) && $stable(limit_o[0].high_mag))
    else $error("rail 1 limits changed on their own");

endmodule

`default_nettype wire

// file: bspg_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module bspg_regs_bench import bspg_pkg::*;;
  // ***************************************************************
  // Stimulus, expected tables, design and store model
  // ***************************************************************
  localparam bspg_regs_t IMG = 40'h3C_C3_A2_15_3F;
  localparam logic [6:0] MAG [8] = '{7'h1E, 7'h23, 7'h28, 7'h32, 7'h3C, 7'h46, 7'h50, 7'h64};
  localparam logic [7:0] OFS [5] = '{8'h14, 8'h15, 8'h18, 8'h19, 8'h1A};
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  bspg_req_t req_i = '0;
  bspg_rsp_t rsp_o;
  logic fire = 1'b0;
  logic nvm_load;
  bspg_regs_t nvm_image;
  logic [BSPG_RAILS-1:0] mv_range_i = '0;
  logic [7:0] code_a;
  logic [7:0] code_b;
  bspg_limit_t [BSPG_RAILS-1:0] limit_o;
  logic loaded_o;
  logic [7:0] rd;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;

  bspg_regs bspg_regs_inst (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .req_i(req_i),
    .rsp_o(rsp_o),
    .nvm_load_i(nvm_load),
    .nvm_image_i(nvm_image),
    .mv_range_i(mv_range_i),
    .rail4_code_a_o(code_a),
    .rail4_code_b_o(code_b),
    .limit_o(limit_o),
    .loaded_o(loaded_o)
  );

  bspg_store_model #(.IMAGE(IMG)) bspg_store_model_inst (
    .clk_i(clk_i),
    .fire_i(fire),
    .load_o(nvm_load),
    .image_o(nvm_image)
  );

  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // Hang guard, well above the 150 or so cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      $display("[ERR] run length expected done seen hung");
      conclude();
    end
  end

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One request pulse; answer sampled one cycle later, once settled
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
                        input logic hit);
    @(posedge clk_i);
    #1;
    req_i = {1'b1, wr, addr, wd};
    @(posedge clk_i);
    #1;
    req_i = '0;
    check("ack", rsp_o.ack, 1'b1);
    check("hit", rsp_o.hit, hit);
    rd = rsp_o.rdata;
  endtask

  // Raise one request and let the edge take it; the caller sets the next
  task automatic drive(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    req_i = {1'b1, wr, addr, wd};
    @(posedge clk_i);
    #1;
  endtask

  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ***************************************************************
  // Test sequence
  // ***************************************************************
  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    // Reset contents before any store load
    for (int i = 0; i < 5; i++) begin
      access(1'b0, OFS[i], 8'h00, 1'b1);
      check("reset read", rd, 8'h00);
    end
    check("reset low mag", limit_o[0].low_mag, MAG[0]);
    check("reset loaded", loaded_o, 1'b0);
    $display("Test reset done");
    // Defaults from the store
    @(posedge clk_i);
    #1;
    fire = 1'b1;
    @(posedge clk_i);
    #1;
    fire = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    check("loaded", loaded_o, 1'b1);
    check("code a", code_a, IMG.rail4_code_a);
    check("code b", code_b, IMG.rail4_code_b);
    for (int r = 0; r < 3; r++) begin
      check("store low", limit_o[r].low_mag, MAG[IMG.win[r].low_limit]);
      check("store high", limit_o[r].high_mag, MAG[IMG.win[r].high_limit]);
      access(1'b0, OFS[r+2], 8'h00, 1'b1);
      check("store window", rd, IMG.win[r]);
    end
    $display("Test store load done");
    // Full-width writes, reserved bits included, then an unmapped place
    for (int i = 0; i < 5; i++) begin
      access(1'b1, OFS[i], 8'hC0 | 8'(i), 1'b1);
      access(1'b0, OFS[i], 8'h00, 1'b1);
      check("readback", rd, 8'hC0 | 8'(i));
    end
    check("code a out", code_a, 8'hC0);
    check("code b out", code_b, 8'hC1);
    access(1'b1, 8'h16, 8'hFF, 1'b0);
    check("unmapped rdata", rd, 8'h00);
    access(1'b0, 8'h15, 8'h00, 1'b1);
    check("after unmapped", rd, 8'hC1);
    // Back to back: a write, then a read of it in the very next cycle
    @(posedge clk_i);
    #1;
    drive(1'b1, OFS[1], 8'h5A);
    drive(1'b0, OFS[1], 8'h00);
    check("b2b ack", rsp_o.ack, 1'b1);
    check("b2b read b", rsp_o.rdata, 8'h5A);
    drive(1'b1, OFS[2], 8'h80);
    drive(1'b0, OFS[2], 8'h00);
    check("b2b reserved", rsp_o.rdata, 8'h80);
    drive(1'b1, OFS[3], 8'h1D);
    req_i = '0;
    @(posedge clk_i);
    #1;
    check("b2b rail2 low", limit_o[1].low_mag, MAG[3]);
    check("b2b rail2 high", limit_o[1].high_mag, MAG[5]);
    $display("Test access done");
    // Every threshold code on every rail, low and high opposed
    for (int c = 0; c < 8; c++) begin
      for (int r = 0; r < 3; r++) begin
        access(1'b1, OFS[r+2], {2'b10, 3'(c), 3'(7 - c)}, 1'b1);
      end
      repeat (2) @(posedge clk_i);
      #1;
      check("rail1 low", limit_o[0].low_mag, MAG[c]);
      check("rail1 high", limit_o[0].high_mag, MAG[7-c]);
      check("rail2 low", limit_o[1].low_mag, MAG[c]);
      check("rail2 high", limit_o[1].high_mag, MAG[7-c]);
      check("rail3 low", limit_o[2].low_mag, MAG[c]);
      check("rail3 high", limit_o[2].high_mag, MAG[7-c]);
    end
    $display("Test codes done");
    // Unit per rail follows its range pin
    for (int k = 0; k < 2; k++) begin
      mv_range_i = (k == 0) ? 3'b101 : 3'b010;
      repeat (4) @(posedge clk_i);
      #1;
      for (int r = 0; r < 3; r++) begin
        check("unit", limit_o[r].in_mv, mv_range_i[r]);
      end
    end
    $display("Test units done");
    // Mid-run reset clears contents and the loaded flag
    nrst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    check("mid reset loaded", loaded_o, 1'b0);
    check("mid reset code b", code_b, 8'h00);
    check("mid reset low mag", limit_o[0].low_mag, MAG[0]);
    nrst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    access(1'b0, OFS[2], 8'h00, 1'b1);
    check("mid reset window", rd, 8'h00);
    $display("Test mid reset done");
    conclude();
  end
endmodule

`default_nettype wire

// file: bspg_rst_sync.sv
`timescale 1ns/1ps
`default_nettype none

module bspg_rst_sync
  import bspg_pkg::*;
(
  input wire logic clk_i,      // System clock
  input wire logic nrst_i,     // Raw reset, active low
  output logic rst_n_o         // Released reset, active low
);

  logic [BSPG_SYNC_STAGES-1:0] st_q;
  logic [BSPG_SYNC_STAGES-1:0] st_d;

  // Shift a one in after release; assertion stays asynchronous
  always_comb begin
    st_d = {st_q[BSPG_SYNC_STAGES-2:0], 1'b1};
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rst_n_o = st_q[BSPG_SYNC_STAGES-1];

endmodule

`default_nettype wire

// file: bspg_store_model.sv
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// Nonvolatile store model, far side of the default load
// ***************************************************************
module bspg_store_model
  import bspg_pkg::*;
#(
  parameter bspg_regs_t IMAGE = 40'h3C_C3_A2_15_3F
) (
  input wire logic clk_i,       // System clock
  input wire logic fire_i,      // Bench asks for one load
  output logic load_o,          // Load pulse, one cycle
  output bspg_regs_t image_o    // Image, valid with the pulse only
);
  // Image scrambled outside the pulse, so a late sample shows up
  always_ff @(posedge clk_i) begin
    load_o <= fire_i;
    image_o <= fire_i ? IMAGE : ~IMAGE;
  end
endmodule

`default_nettype wire
